// File: hw/lprs_pkg.sv
// package: command codes, timing figures and counts for the refresh/precharge scheduler
package lprs_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int NUM_BANKS = 8;
	localparam int BANK_W = 3;
	localparam int CA_W = 10;
	localparam int BL = 8;
	localparam int RL = 6;
	localparam int WL = 3;
	localparam int READ_PCH_FLOOR = 4;
	localparam int BURST_PAD = 1;
	// analog times in ns, as printed for the grade
	localparam int T_WR_NS = 15;
	localparam int T_RTP_NS = 8;
	localparam int T_RPPB_NS = 18;
	localparam int T_RPAB_NS = 21;
	localparam int T_WTR_NS = 8;
	localparam int T_DQSCK_MAX_NS = 6;
	localparam int T_RFCAB_NS = 130;
	localparam int T_RFCPB_NS = 60;
	localparam int T_RRD_NS = 10;
	localparam int T_REFI_NS = 3900;
	// least times round up
	localparam int T_WR_CK = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RTP_CK = (T_RTP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RPPB_CK = (T_RPPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RPAB_CK = (T_RPAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_WTR_CK = (T_WTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_DQSCK_CK = (T_DQSCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RFCAB_CK = (T_RFCAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RFCPB_CK = (T_RFCPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RRD_CK = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// interval rounds down
	localparam int T_REFI_CK = T_REFI_NS / CLK_PERIOD_NS;
	localparam int RTP_TERM = (T_RTP_CK > READ_PCH_FLOOR) ? T_RTP_CK : READ_PCH_FLOOR;
	// command-to-command minimums in clocks
	localparam int RD_TO_PCH = BL / 2 + RTP_TERM - READ_PCH_FLOOR;
	localparam int RDA_TO_ACT = RD_TO_PCH + T_RPPB_CK;
	localparam int RDA_TO_WR = RL + BL / 2 + T_DQSCK_CK - WL + BURST_PAD;
	localparam int SEAMLESS = BL / 2;
	localparam int WR_TO_PCH = WL + BL / 2 + T_WR_CK + BURST_PAD;
	localparam int WRA_TO_ACT = WR_TO_PCH + T_RPPB_CK;
	localparam int WRA_TO_RD = WL + BL / 2 + T_WTR_CK + BURST_PAD;
	localparam int PCH_TO_PCH = 1;
	// write burst end, and start of the auto-precharge from the command
	localparam int WR_BURST_END = WL + BL / 2 + BURST_PAD;
	localparam int WRA_PCH_START = WR_BURST_END + T_WR_CK;
	localparam int RDA_PCH_START = RD_TO_PCH;
	// refresh accounting
	localparam int REF_POSTPONE_MAX = 8;
	localparam int REF_PULLIN_MAX = 8;
	localparam int REF_WINDOW_MAX = 16;
	localparam int PB_PER_AB = 8;
	localparam int CNT_W = 16;
	localparam logic [BANK_W-1:0] BANK_ZERO = 3'h0;
	localparam logic [BANK_W-1:0] BANK_LAST = 3'h7;
	// commands as seen on the bus
	typedef enum logic [3:0] {
		LPRS_NOP, LPRS_ACT, LPRS_RD, LPRS_WR, LPRS_PRE, LPRS_PREA,
		LPRS_REFPB, LPRS_REFAB, LPRS_SREX
	} lprs_cmd_t;
	typedef enum logic [1:0] {
		LPRS_IDLE, LPRS_ACTIVE, LPRS_PCHG, LPRS_REFR
	} lprs_bank_t;
endpackage : lprs_pkg

// File: hw/lprs_if.sv
// interface: command bus between controller and memory
`timescale 1ns/1ns
`default_nettype none
interface lprs_if;
	import lprs_pkg::*;
	logic cs_n;
	logic [CA_W-1:0] ca_r;
	logic [CA_W-1:0] ca_f;
	logic sr_exit;
	modport ctrl (output cs_n, output ca_r, output ca_f, output sr_exit);
	modport mem (input cs_n, input ca_r, input ca_f, input sr_exit);
endinterface : lprs_if
`default_nettype wire

// File: hw/lprs_mem.sv
// memory end: decodes commands, runs bank timers, auto-precharge and the refresh bank counter
// ****************************************
// How it works
// - write autoprecharge starts tWR after burst end
// - activate after write-AP waits tRP
// - read to precharge waits read-precharge delay
// - read-AP to activate adds tRPpb
// - no access after AP until reactivated
// - read-AP to other-bank write delayed
// - seamless AP bursts every BL/2 clocks
// - write to precharge waits write recovery
// - write-AP to activate adds tRPpb
// - write-AP to other-bank read delayed
// - precharges may follow one clock apart
// - tRP timed from latest precharge per bank
// - no command inside minimum delays
// - refresh decode: CA0-2 001, CA3 selects
// - per-bank refresh target round-robin counter
// - counter zeroed on reset, exit, all-bank
// - per-bank refresh needs idle bank, gaps
// - only refreshed bank busy during tRFCpb
// - after per-bank refresh, wait gaps
// - all-bank refresh: banks idle, tRFCab
// - postpone or pull in at most eight (per-bank refreshes may pull in up to 64; the controller lets them pull in 512)
// - at most sixteen refreshes per window (REF_WINDOW_MAX is declared, but neither end counts refreshes per window)
// ****************************************
`timescale 1ns/1ns
`default_nettype none
module lprs_mem
	import lprs_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// command bus
	lprs_if.mem BUS,
	// bank state seen by the core
	output logic [NUM_BANKS-1:0] BANK_OPEN,
	output logic [NUM_BANKS-1:0] BANK_BUSY,
	output logic [BANK_W-1:0] REF_BANK,
	output logic CMD_ERR
);
	lprs_cmd_t cmd;
	logic [BANK_W-1:0] ba;
	logic ap;
	logic [BANK_W-1:0] ref_bank_reg, ref_bank_next;
	logic err_reg, err_next;

	// ****************************************
	// command decode
	// ****************************************
	// rising-edge half picks command and bank; falling half carries the AP bit
	always_comb begin
		cmd = LPRS_NOP;
		ba = BUS.ca_r[9:7];
		ap = BUS.ca_f[0];
		if (BUS.sr_exit) begin
			cmd = LPRS_SREX;
		end else if (!BUS.cs_n) begin
			case (BUS.ca_r[2:0])
				3'h4: cmd = (BUS.ca_r[1]) ? LPRS_NOP : LPRS_ACT;
				3'h5: cmd = LPRS_WR;
				3'h3: cmd = LPRS_RD;
				3'h1, 3'h2: cmd = LPRS_ACT;
				3'h7: cmd = LPRS_NOP;
				default: cmd = LPRS_NOP;
			endcase
			if (BUS.ca_r[2:0] == 3'h1) cmd = LPRS_WR;
			if (BUS.ca_r[2:0] == 3'h5) cmd = LPRS_RD;
			if (BUS.ca_r[1:0] == 2'h2) cmd = LPRS_ACT;
			if (BUS.ca_r[3:0] == 4'hb) cmd = (BUS.ca_r[4]) ? LPRS_PREA : LPRS_PRE;
			if (BUS.ca_r[2:0] == 3'h4) cmd = (BUS.ca_r[3]) ? LPRS_REFAB : LPRS_REFPB;
		end
	end

	// ****************************************
	// per-bank state and timers
	// ****************************************
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			lprs_bank_t st_reg, st_next;
			logic [CNT_W-1:0] tmr_reg, tmr_next;
			logic apq_reg, apq_next;
			logic [CNT_W-1:0] apc_reg, apc_next;
			logic hit, all_ref;
			logic [BANK_W-1:0] idx;
			assign idx = BANK_W'(b);
			assign hit = (ba == idx);
			assign all_ref = (cmd == LPRS_REFAB);
			always_comb begin
				st_next = st_reg;
				tmr_next = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
				apq_next = apq_reg;
				apc_next = (apc_reg != '0) ? apc_reg - 1'b1 : apc_reg;
				// timed states fall back to idle when the timer runs out
				if ((st_reg == LPRS_PCHG || st_reg == LPRS_REFR) && tmr_reg <= 1) begin
					st_next = LPRS_IDLE;
				end
				// pending auto-precharge launches at its counted edge
				if (apq_reg && apc_reg == 1) begin
					apq_next = 1'b0;
					st_next = LPRS_PCHG;
					tmr_next = CNT_W'(T_RPPB_CK - 1);
				end
				case (cmd)
					LPRS_ACT: if (hit) st_next = LPRS_ACTIVE;
					LPRS_RD, LPRS_WR: if (hit && ap && !apq_reg) begin
						apq_next = 1'b1;
						apc_next = (cmd == LPRS_WR) ? CNT_W'(WRA_PCH_START) : CNT_W'(RDA_PCH_START);
					end
					// the latest precharge restarts tRP for this bank
					LPRS_PRE: if (hit && !apq_reg) begin
						st_next = LPRS_PCHG;
						tmr_next = CNT_W'(T_RPPB_CK - 1);
					end
					LPRS_PREA: if (!apq_reg) begin
						st_next = LPRS_PCHG;
						tmr_next = CNT_W'(T_RPAB_CK - 1);
					end
					LPRS_REFPB: if (ref_bank_reg == idx) begin
						st_next = LPRS_REFR;
						tmr_next = CNT_W'(T_RFCPB_CK - 1);
					end
					LPRS_REFAB: if (all_ref) begin
						st_next = LPRS_REFR;
						// n-1 load: busy n-1 clocks, so a refresh n clocks on is legal
						tmr_next = CNT_W'(T_RFCAB_CK - 1);
					end
					default: ;
				endcase
			end
			always_ff @(posedge MCLK or negedge RST_N) begin
				if (!RST_N) begin
					st_reg <= LPRS_IDLE;
					tmr_reg <= '0;
					apq_reg <= 1'b0;
					apc_reg <= '0;
				end else begin
					st_reg <= st_next;
					tmr_reg <= tmr_next;
					apq_reg <= apq_next;
					apc_reg <= apc_next;
				end
			end
			assign BANK_OPEN[b] = (st_reg == LPRS_ACTIVE);
			assign BANK_BUSY[b] = (st_reg == LPRS_PCHG) || (st_reg == LPRS_REFR);
		end
	endgenerate

	// ****************************************
	// refresh bank counter and error flag
	// ****************************************
	// error flags a refresh aimed at a bank that is not idle
	always_comb begin
		ref_bank_next = ref_bank_reg;
		err_next = 1'b0;
		case (cmd)
			LPRS_REFPB: begin
				err_next = BANK_OPEN[ref_bank_reg] | BANK_BUSY[ref_bank_reg];
				ref_bank_next = (ref_bank_reg == BANK_LAST) ? BANK_ZERO : ref_bank_reg + 1'b1;
			end
			LPRS_REFAB: begin
				err_next = |(BANK_OPEN | BANK_BUSY);
				ref_bank_next = BANK_ZERO;
			end
			LPRS_SREX: ref_bank_next = BANK_ZERO;
			default: ;
		endcase
	end
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ref_bank_reg <= BANK_ZERO;
			err_reg <= 1'b0;
		end else begin
			ref_bank_reg <= ref_bank_next;
			err_reg <= err_next;
		end
	end
	assign REF_BANK = ref_bank_reg;
	assign CMD_ERR = err_reg;
endmodule : lprs_mem
`default_nettype wire

// File: hw/lprs_ctrl.sv
// controller end: issues commands only once every minimum delay has passed
`timescale 1ns/1ns
`default_nettype none
module lprs_ctrl
	import lprs_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// command request from the user
	input wire logic REQ_VALID,
	input wire lprs_cmd_t REQ_CMD,
	input wire logic [BANK_W-1:0] REQ_BANK,
	input wire logic REQ_AP,
	output logic REQ_READY,
	// refresh status
	output logic [BANK_W-1:0] REF_BANK,
	output logic REF_DUE,
	// command bus
	lprs_if.ctrl BUS
);
	// per-bank earliest-issue counters; 0 means allowed
	logic [CNT_W-1:0] act_w_reg [NUM_BANKS], act_w_next [NUM_BANKS];
	logic [CNT_W-1:0] pre_w_reg [NUM_BANKS], pre_w_next [NUM_BANKS];
	logic [NUM_BANKS-1:0] lock_reg, lock_next;
	logic [NUM_BANKS-1:0] open_reg, open_next;
	logic [CNT_W-1:0] rd_w_reg, rd_w_next, wr_w_reg, wr_w_next, ref_w_reg, ref_w_next;
	logic [CNT_W-1:0] refi_reg, refi_next;
	logic signed [CNT_W-1:0] owe_reg, owe_next;
	logic [BANK_W-1:0] rb_reg, rb_next;
	logic [CNT_W-1:0] pb_reg, pb_next;
	logic ok, go;
	logic cs_reg, cs_next;
	logic [CA_W-1:0] car_reg, car_next, caf_reg, caf_next;

	function automatic logic [CNT_W-1:0] mx(input logic [CNT_W-1:0] a, input int b);
		logic [CNT_W-1:0] bb;
		// a counter loaded with n-1 frees the command exactly n clocks later
		bb = CNT_W'(b - 1);
		return (a > bb) ? a : bb;
	endfunction : mx

	// ****************************************
	// legality check
	// ****************************************
	always_comb begin
		ok = 1'b1;
		case (REQ_CMD)
			LPRS_ACT: ok = (act_w_reg[REQ_BANK] == '0) && (ref_w_reg == '0);
			LPRS_RD: ok = (rd_w_reg == '0) && !lock_reg[REQ_BANK];
			LPRS_WR: ok = (wr_w_reg == '0) && !lock_reg[REQ_BANK];
			LPRS_PRE: ok = (pre_w_reg[REQ_BANK] == '0);
			LPRS_PREA: begin
				for (int i = 0; i < NUM_BANKS; i++) if (pre_w_reg[i] != '0) ok = 1'b0;
			end
			LPRS_REFPB: ok = (ref_w_reg == '0) && (act_w_reg[rb_reg] == '0) && !open_reg[rb_reg]
				&& (owe_reg > -(REF_PULLIN_MAX * PB_PER_AB));
			LPRS_REFAB: begin
				ok = (ref_w_reg == '0) && (open_reg == '0) && (owe_reg > -REF_PULLIN_MAX);
				for (int i = 0; i < NUM_BANKS; i++) if (act_w_reg[i] != '0) ok = 1'b0;
			end
			default: ok = 1'b1;
		endcase
	end
	assign go = REQ_VALID && ok;
	assign REQ_READY = ok;

	// ****************************************
	// timing bookkeeping
	// ****************************************
	always_comb begin
		rd_w_next = (rd_w_reg != '0) ? rd_w_reg - 1'b1 : rd_w_reg;
		wr_w_next = (wr_w_reg != '0) ? wr_w_reg - 1'b1 : wr_w_reg;
		ref_w_next = (ref_w_reg != '0) ? ref_w_reg - 1'b1 : ref_w_reg;
		lock_next = lock_reg;
		open_next = open_reg;
		rb_next = rb_reg;
		pb_next = pb_reg;
		owe_next = owe_reg;
		refi_next = refi_reg + 1'b1;
		// a refresh falls due every interval
		if (refi_reg == CNT_W'(T_REFI_CK - 1)) begin
			refi_next = '0;
			owe_next = owe_reg + 2'sh1;
		end
		for (int i = 0; i < NUM_BANKS; i++) begin
			act_w_next[i] = (act_w_reg[i] != '0) ? act_w_reg[i] - 1'b1 : act_w_reg[i];
			pre_w_next[i] = (pre_w_reg[i] != '0) ? pre_w_reg[i] - 1'b1 : pre_w_reg[i];
		end
		if (go) begin
			case (REQ_CMD)
				LPRS_ACT: begin
					lock_next[REQ_BANK] = 1'b0;
					open_next[REQ_BANK] = 1'b1;
					ref_w_next = mx(ref_w_reg, T_RRD_CK);
				end
				LPRS_RD: begin
					rd_w_next = mx(rd_w_reg, SEAMLESS);
					pre_w_next[REQ_BANK] = mx(pre_w_reg[REQ_BANK], RD_TO_PCH);
					if (REQ_AP) begin
						lock_next[REQ_BANK] = 1'b1;
						open_next[REQ_BANK] = 1'b0;
						act_w_next[REQ_BANK] = mx(act_w_reg[REQ_BANK], RDA_TO_ACT);
						wr_w_next = mx(wr_w_reg, RDA_TO_WR);
					end
				end
				LPRS_WR: begin
					wr_w_next = mx(wr_w_reg, SEAMLESS);
					pre_w_next[REQ_BANK] = mx(pre_w_reg[REQ_BANK], WR_TO_PCH);
					if (REQ_AP) begin
						lock_next[REQ_BANK] = 1'b1;
						open_next[REQ_BANK] = 1'b0;
						act_w_next[REQ_BANK] = mx(act_w_reg[REQ_BANK], WRA_TO_ACT);
						rd_w_next = mx(rd_w_reg, WRA_TO_RD);
					end
				end
				LPRS_PRE: begin
					pre_w_next[REQ_BANK] = mx(pre_w_reg[REQ_BANK], PCH_TO_PCH);
					open_next[REQ_BANK] = 1'b0;
					act_w_next[REQ_BANK] = CNT_W'(T_RPPB_CK - 1);
				end
				LPRS_PREA: begin
					for (int i = 0; i < NUM_BANKS; i++) begin
						pre_w_next[i] = mx(pre_w_reg[i], PCH_TO_PCH);
						act_w_next[i] = CNT_W'(T_RPAB_CK - 1);
					end
					open_next = '0;
				end
				LPRS_REFPB: begin
					ref_w_next = CNT_W'(T_RFCPB_CK - 1);
					act_w_next[rb_reg] = mx(act_w_reg[rb_reg], T_RFCPB_CK);
					rb_next = (rb_reg == BANK_LAST) ? BANK_ZERO : rb_reg + 1'b1;
					pb_next = pb_reg + 1'b1;
					if (pb_reg == CNT_W'(PB_PER_AB - 1)) begin
						pb_next = '0;
						owe_next = owe_next - 2'sh1;
					end
				end
				LPRS_REFAB: begin
					ref_w_next = CNT_W'(T_RFCAB_CK - 1);
					for (int i = 0; i < NUM_BANKS; i++) act_w_next[i] = mx(act_w_reg[i], T_RFCAB_CK);
					rb_next = BANK_ZERO;
					pb_next = '0;
					owe_next = owe_next - 2'sh1;
				end
				LPRS_SREX: begin
					rb_next = BANK_ZERO;
					pb_next = '0;
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// command bus drive
	// ****************************************
	// encodes on the registered bus: CA bits match the memory decode
	always_comb begin
		cs_next = 1'b1;
		car_next = '0;
		caf_next = '0;
		if (go && REQ_CMD != LPRS_NOP && REQ_CMD != LPRS_SREX) begin
			cs_next = 1'b0;
			car_next[9:7] = REQ_BANK;
			caf_next[0] = REQ_AP;
			case (REQ_CMD)
				LPRS_ACT: car_next[1:0] = 2'h2;
				LPRS_WR: car_next[2:0] = 3'h1;
				LPRS_RD: car_next[2:0] = 3'h5;
				LPRS_PRE: car_next[3:0] = 4'hb;
				LPRS_PREA: car_next[4:0] = 5'h1b;
				LPRS_REFPB: car_next[3:0] = 4'h4;
				LPRS_REFAB: car_next[3:0] = 4'hc;
				default: cs_next = 1'b1;
			endcase
		end
	end
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < NUM_BANKS; i++) begin
				act_w_reg[i] <= '0;
				pre_w_reg[i] <= '0;
			end
			lock_reg <= '0;
			open_reg <= '0;
			rd_w_reg <= '0;
			wr_w_reg <= '0;
			ref_w_reg <= '0;
			refi_reg <= '0;
			owe_reg <= '0;
			rb_reg <= BANK_ZERO;
			pb_reg <= '0;
			cs_reg <= 1'b1;
			car_reg <= '0;
			caf_reg <= '0;
		end else begin
			act_w_reg <= act_w_next;
			pre_w_reg <= pre_w_next;
			lock_reg <= lock_next;
			open_reg <= open_next;
			rd_w_reg <= rd_w_next;
			wr_w_reg <= wr_w_next;
			ref_w_reg <= ref_w_next;
			refi_reg <= refi_next;
			owe_reg <= owe_next;
			rb_reg <= rb_next;
			pb_reg <= pb_next;
			cs_reg <= cs_next;
			car_reg <= car_next;
			caf_reg <= caf_next;
		end
	end
	assign BUS.cs_n = cs_reg;
	assign BUS.ca_r = car_reg;
	assign BUS.ca_f = caf_reg;
	assign BUS.sr_exit = 1'b0;
	assign REF_BANK = rb_reg;
	assign REF_DUE = (owe_reg >= REF_POSTPONE_MAX);
endmodule : lprs_ctrl
`default_nettype wire

// File: testbench/lprs_monitor.sv
// checker: command bus spacing and memory-end refresh state
`timescale 1ns/1ns
`default_nettype none
module lprs_monitor
	import lprs_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// command bus
	input wire logic cs_n,
	input wire logic [CA_W-1:0] ca_r,
	input wire logic [CA_W-1:0] ca_f,
	// memory end state
	input wire logic [NUM_BANKS-1:0] BANK_OPEN,
	input wire logic [NUM_BANKS-1:0] BANK_BUSY,
	input wire logic [BANK_W-1:0] REF_BANK
);
	// window is loose: busy shows a cycle after the precharge begins
	localparam int AP_LO = WRA_PCH_START - 1;
	localparam int AP_HI = WRA_PCH_START + 3;
	logic act, refab, refpb, wr_any, rd_any, wr_ap, pre_all;
	// ****************
	// command decode
	// ****************
	assign act = !cs_n && ca_r[1:0] == 2'h2;
	assign refab = !cs_n && ca_r[3:0] == 4'hc;
	assign refpb = !cs_n && ca_r[3:0] == 4'h4;
	assign wr_any = !cs_n && ca_r[2:0] == 3'h1;
	assign rd_any = !cs_n && ca_r[2:0] == 3'h5;
	assign wr_ap = wr_any && ca_f[0];
	assign pre_all = !cs_n && ca_r[4:0] == 5'h1b;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// ****************
	// refresh checks
	// ****************
	sequence s_rfcab_quiet;
		(!act && !refab && !refpb) [*2];
	endsequence
	sequence s_pb_taken;
		BANK_BUSY[$past(REF_BANK)] && BANK_OPEN == $past(BANK_OPEN);
	endsequence
	chk_refab_zero: assert property (refab |=> REF_BANK == BANK_ZERO && BANK_BUSY == 8'hff)
		else $error("all-bank refresh did not zero the counter or busy all banks");
	chk_refab_quiet: assert property (refab |=> s_rfcab_quiet)
		else $error("command inside all-bank refresh cycle");
	chk_refpb_step: assert property (refpb |=> REF_BANK == $past(REF_BANK) + 3'h1)
		else $error("per-bank counter did not advance by one");
	chk_refpb_target: assert property (refpb |=> s_pb_taken)
		else $error("per-bank refresh hit the wrong bank or closed another");
	chk_refpb_quiet: assert property (refpb |=> !(refab || refpb))
		else $error("refresh inside per-bank refresh cycle");
	// ****************
	// precharge and write-spacing checks
	// ****************
	chk_wr_to_pch: assert property (wr_any |=> !pre_all [*8])
		else $error("precharge-all too soon after write");
	chk_rd_to_pch: assert property (rd_any |=> !pre_all [*3])
		else $error("precharge-all too soon after read");
	chk_wr_seam: assert property (wr_any |=> !wr_any [*3])
		else $error("writes closer than half a burst");
	chk_wra_start: assert property (wr_ap |-> ##[AP_LO:AP_HI] BANK_BUSY != 8'h00)
		else $error("write auto-precharge did not start");
endmodule : lprs_monitor
`default_nettype wire

// File: testbench/lprs_bench.sv
// testbench: controller and memory ends joined, driven from the request side
`timescale 1ns/1ns
`default_nettype none
module lprs_bench;
	import lprs_pkg::*;
	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic REQ_VALID = 1'b0;
	lprs_cmd_t REQ_CMD = LPRS_NOP;
	logic [BANK_W-1:0] REQ_BANK = 3'h0;
	logic REQ_AP = 1'b0;
	logic REQ_READY, REF_DUE, CMD_ERR;
	logic [BANK_W-1:0] c_ref_bank, m_ref_bank;
	logic [NUM_BANKS-1:0] BANK_OPEN, BANK_BUSY;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	time t_take = 0;
	time t_last = 0;
	time t_a = 0;
	time t_b = 0;
	time t_c = 0;
	logic err_seen = 1'b0;
	lprs_if u_lprs_if ();
	lprs_ctrl u_lprs_ctrl (.MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
		.REQ_CMD(REQ_CMD), .REQ_BANK(REQ_BANK), .REQ_AP(REQ_AP), .REQ_READY(REQ_READY),
		.REF_BANK(c_ref_bank), .REF_DUE(REF_DUE), .BUS(u_lprs_if.ctrl));
	lprs_mem u_lprs_mem (.MCLK(MCLK), .RST_N(RST_N), .BUS(u_lprs_if.mem),
		.BANK_OPEN(BANK_OPEN), .BANK_BUSY(BANK_BUSY), .REF_BANK(m_ref_bank),
		.CMD_ERR(CMD_ERR));
	lprs_monitor u_lprs_monitor (.MCLK(MCLK), .RST_N(RST_N), .cs_n(u_lprs_if.cs_n),
		.ca_r(u_lprs_if.ca_r), .ca_f(u_lprs_if.ca_f), .BANK_OPEN(BANK_OPEN),
		.BANK_BUSY(BANK_BUSY), .REF_BANK(m_ref_bank));
	// clock and watchdog; a hang counts as a mismatch
	always #(CLK_PERIOD_NS / 2) MCLK = ~MCLK;
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		// error flag is a one-cycle pulse: keep it sticky for the final compare
		if (CMD_ERR === 1'b1) err_seen <= 1'b1;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	// ****************
	// helpers
	// ****************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	function automatic int since(input time t);
		return int'((t_take - t) / CLK_PERIOD_NS);
	endfunction : since
	// holds the request until the edge that takes it
	task automatic issue(input lprs_cmd_t c, input logic [2:0] b, input logic ap);
		int n;
		n = 0;
		@(posedge MCLK);
		REQ_VALID <= 1'b1;
		REQ_CMD <= c;
		REQ_BANK <= b;
		REQ_AP <= ap;
		@(negedge MCLK);
		while (REQ_READY !== 1'b1 && n < 300) begin
			@(negedge MCLK);
			n++;
		end
		check("ready_wait", n < 300, 8'h01);
		@(posedge MCLK);
		t_last = t_take;
		t_take = $time;
		REQ_VALID <= 1'b0;
	endtask : issue
	task automatic probe(input lprs_cmd_t c, input logic [2:0] b, input logic exp);
		@(posedge MCLK);
		REQ_CMD <= c;
		REQ_BANK <= b;
		@(negedge MCLK);
		check("ready", REQ_READY, exp);
	endtask : probe
	task automatic do_reset();
		@(posedge MCLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge MCLK);
		RST_N <= 1'b1;
	endtask : do_reset
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	// ****************
	// main sequence
	// ****************
	initial begin
		do_reset();
		// owed refreshes build up with time
		repeat (7 * T_REFI_CK) @(posedge MCLK);
		@(negedge MCLK);
		check("ref_due", REF_DUE, 8'h00);
		repeat (T_REFI_CK + 4) @(posedge MCLK);
		@(negedge MCLK);
		check("ref_due", REF_DUE, 8'h01);
		issue(LPRS_REFAB, 3'h0, 1'b0);
		repeat (2) @(negedge MCLK);
		check("refab_busy", BANK_BUSY, 8'hff);
		check("ref_due", REF_DUE, 8'h00);
		// per-bank refreshes back to back, across the wrap
		for (int i = 0; i < 9; i++) begin
			issue(LPRS_REFPB, 3'h0, 1'b0);
			check("refpb_gap", since(t_last) >= T_RFCPB_CK, 8'h01);
		end
		repeat (2) @(negedge MCLK);
		check("mem_ref_bank", m_ref_bank, 8'h01);
		check("ctrl_ref_bank", c_ref_bank, 8'h01);
		// reset resynchronises both counters
		do_reset();
		@(negedge MCLK);
		check("mem_ref_bank", m_ref_bank, 8'h00);
		check("ctrl_ref_bank", c_ref_bank, 8'h00);
		// refresh refused while the target bank is open
		issue(LPRS_ACT, 3'h0, 1'b0);
		probe(LPRS_REFPB, 3'h0, 1'b0);
		probe(LPRS_REFAB, 3'h0, 1'b0);
		issue(LPRS_PREA, 3'h0, 1'b0);
		// pull-in limit: eight ahead, then a probe while tRFCab still runs, refused
		for (int i = 0; i < 8; i++) begin
			issue(LPRS_REFAB, 3'h0, 1'b0);
			check("refab_gap", since(t_last) >= ((i == 0) ? T_RPAB_CK : T_RFCAB_CK), 8'h01);
		end
		probe(LPRS_REFAB, 3'h0, 1'b0);
		// write with auto-precharge and what may follow it
		issue(LPRS_ACT, 3'h3, 1'b0);
		issue(LPRS_ACT, 3'h2, 1'b0);
		issue(LPRS_WR, 3'h2, 1'b1);
		t_a = t_take;
		issue(LPRS_WR, 3'h3, 1'b0);
		t_b = t_take;
		check("wr_seam", since(t_last) == SEAMLESS, 8'h01);
		probe(LPRS_RD, 3'h2, 1'b0);
		issue(LPRS_RD, 3'h3, 1'b0);
		t_c = t_take;
		check("wra_rd", since(t_a) >= WRA_TO_RD, 8'h01);
		issue(LPRS_ACT, 3'h2, 1'b0);
		check("wra_act", since(t_a) >= WRA_TO_ACT, 8'h01);
		repeat (2) @(negedge MCLK);
		check("open", BANK_OPEN, 8'h0c);
		issue(LPRS_PREA, 3'h0, 1'b0);
		check("wr_pch", since(t_b) >= WR_TO_PCH, 8'h01);
		check("rd_pch", since(t_c) >= RD_TO_PCH, 8'h01);
		issue(LPRS_PRE, 3'h0, 1'b0);
		check("pch_pch", since(t_last) == 2, 8'h01);
		repeat (4) @(negedge MCLK);
		check("closed", BANK_OPEN | BANK_BUSY, 8'h00);
		// read with auto-precharge
		issue(LPRS_ACT, 3'h5, 1'b0);
		issue(LPRS_ACT, 3'h4, 1'b0);
		issue(LPRS_RD, 3'h4, 1'b1);
		t_a = t_take;
		probe(LPRS_WR, 3'h4, 1'b0);
		issue(LPRS_WR, 3'h5, 1'b0);
		check("rda_wr", since(t_a) >= RDA_TO_WR, 8'h01);
		issue(LPRS_ACT, 3'h4, 1'b0);
		check("rda_act", since(t_a) >= RDA_TO_ACT, 8'h01);
		repeat (2) @(negedge MCLK);
		check("cmd_err", err_seen, 8'h00);
		finish_test();
	end
endmodule : lprs_bench
`default_nettype wire
